//--- logic/tsg_pkg.sv
package tsg_pkg;
    // Register indices (word addresses)
    localparam logic [3:0] TSG_ADDR_CTRL = 4'h0;
    localparam logic [3:0] TSG_ADDR_GATE = 4'h1;
    localparam logic [3:0] TSG_ADDR_CNTL = 4'h2;
    localparam logic [3:0] TSG_ADDR_CNTH = 4'h3;
    localparam logic [3:0] TSG_ADDR_FLAG = 4'h4;
    // Control register fields
    localparam int TSG_CS_LSB = 6;
    localparam int TSG_PS_LSB = 4;
    localparam int TSG_OSC_BIT = 3;
    localparam int TSG_SYNC_BIT = 2;
    localparam int TSG_ON_BIT = 0;
    localparam logic [7:0] TSG_CTRL_WMASK = 8'hFD;
    // Gate register fields
    localparam int TSG_GE_BIT = 7;
    localparam int TSG_POL_BIT = 6;
    localparam int TSG_TM_BIT = 5;
    localparam int TSG_SPM_BIT = 4;
    localparam int TSG_GO_BIT = 3;
    localparam int TSG_VAL_BIT = 2;
    localparam int TSG_GSS_LSB = 0;
    // Flag register fields
    localparam int TSG_ROLL_BIT = 0;
    localparam int TSG_GEVT_BIT = 1;
    localparam logic [7:0] TSG_RST_BYTE = 8'h00;
    localparam logic [15:0] TSG_CNT_MAX = 16'hFFFF;
    // Clock source codes
    localparam logic [1:0] TSG_CS_INSTR = 2'h0;
    localparam logic [1:0] TSG_CS_SYS = 2'h1;
    localparam logic [1:0] TSG_CS_PIN = 2'h2;
    localparam logic [1:0] TSG_CS_CAP = 2'h3;
    // Gate source codes
    localparam logic [1:0] TSG_GS_PIN = 2'h0;
    localparam logic [1:0] TSG_GS_OVF = 2'h1;
    localparam logic [1:0] TSG_GS_CMP1 = 2'h2;
    localparam logic [1:0] TSG_GS_CMP2 = 2'h3;

    // External sources bundled
    typedef struct packed {
        logic ext_clk_pin;
        logic osc_clk;
        logic cap_sense_osc;
        logic gate_pin;
        logic ovf_pulse;
        logic cmp_one_out;
        logic cmp_two_out;
    } tsg_src_s;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tsg_bus_s;

    // Whole block state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] gate;
        logic [15:0] count;
        logic [1:0] quarter;
        logic [2:0] prescale;
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic gate_prev;
        logic toggle;
        logic spm_run;
        logic val_prev;
        logic rollover_flag;
        logic gate_event_flag;
        logic osc_en;
        logic [7:0] rdata;
    } tsg_state_s;
endpackage

//--- logic/tsg_timer.sv
`timescale 1ns/1ps
module tsg_timer
    import tsg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Register port
    input wire tsg_pkg::tsg_bus_s bus,
    output logic [7:0] rdata,
    // External sources
    input wire tsg_pkg::tsg_src_s src,
    // Status outputs
    output logic dedicated_osc_en,
    output logic rollover_flag,
    output logic gate_event_flag
);
    import tsg_pkg::*;

    tsg_state_s s_q;
    tsg_state_s s_d;

    // Write decode shared by all register updates
    function automatic logic wr_hit(input tsg_bus_s b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    logic [1:0] cs;
    logic [1:0] ps;
    logic [1:0] gss;
    logic raw_clk;
    logic sel_clk;
    logic tick;
    logic ps_tick;
    logic gate_raw;
    logic gate_pol;
    logic gate_rise;
    logic gate_sel;
    logic gate_ok;
    logic cnt_en;

    // Clock source, synchroniser bypass, prescaler and gate selection
    always_comb
    begin
        cs = s_q.ctrl[TSG_CS_LSB +: 2];
        ps = s_q.ctrl[TSG_PS_LSB +: 2];
        gss = s_q.gate[TSG_GSS_LSB +: 2];
        // Source 10 picks pin or crystal by oscillator enable
        raw_clk = s_q.ctrl[TSG_OSC_BIT] ? src.osc_clk : src.ext_clk_pin;
        if (cs == TSG_CS_CAP)
        begin
            raw_clk = src.cap_sense_osc;
        end
        // Synchronised path when sync bit is zero
        sel_clk = s_q.ctrl[TSG_SYNC_BIT] ? raw_clk : s_q.clk_s2;
        case (cs)
            TSG_CS_INSTR: tick = (s_q.quarter == 2'h3);
            TSG_CS_SYS: tick = 1'b1;
            default: tick = sel_clk && !s_q.clk_prev;
        endcase
        // Divide selected edges
        case (ps)
            2'h0: ps_tick = tick;
            2'h1: ps_tick = tick && s_q.prescale[0];
            2'h2: ps_tick = tick && (s_q.prescale[1:0] == 2'h3);
            default: ps_tick = tick && (s_q.prescale == 3'h7);
        endcase
        // Gate input select
        case (gss)
            TSG_GS_PIN: gate_raw = src.gate_pin;
            TSG_GS_OVF: gate_raw = src.ovf_pulse;
            TSG_GS_CMP1: gate_raw = src.cmp_one_out;
            default: gate_raw = src.cmp_two_out;
        endcase
        gate_pol = s_q.gate[TSG_POL_BIT] ? gate_raw : !gate_raw;
        gate_rise = gate_pol && !s_q.gate_prev;
        // Toggle flop replaces level in toggle mode
        gate_sel = s_q.gate[TSG_TM_BIT] ? s_q.toggle : gate_pol;
        // Single-pulse window
        gate_ok = s_q.gate[TSG_SPM_BIT] ? (s_q.spm_run && gate_sel) : gate_sel;
        // Gate enable only matters while on
        cnt_en = s_q.ctrl[TSG_ON_BIT] && (!s_q.gate[TSG_GE_BIT] || gate_ok);
    end

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.rdata = TSG_RST_BYTE;
        s_d.clk_s1 = raw_clk;
        s_d.clk_s2 = s_q.clk_s1;
        s_d.clk_prev = sel_clk;
        s_d.quarter = s_q.quarter + 2'h1;
        s_d.gate_prev = gate_pol;
        s_d.osc_en = s_q.ctrl[TSG_OSC_BIT];
        if (tick && s_q.ctrl[TSG_ON_BIT])
        begin
            s_d.prescale = s_q.prescale + 3'h1;
        end
        // Toggle flop, held clear when off or mode clear
        if (!s_q.ctrl[TSG_ON_BIT] || !s_q.gate[TSG_TM_BIT])
        begin
            s_d.toggle = 1'b0;
        end
        else if (gate_rise)
        begin
            s_d.toggle = !s_q.toggle;
        end
        // Pulse acquisition: start on gate active, done when it drops
        if (s_q.gate[TSG_GO_BIT] && s_q.gate[TSG_SPM_BIT])
        begin
            if (!s_q.spm_run && gate_sel)
            begin
                s_d.spm_run = 1'b1;
            end
            else if (s_q.spm_run && !gate_sel)
            begin
                s_d.spm_run = 1'b0;
                s_d.gate[TSG_GO_BIT] = 1'b0;
            end
        end
        else
        begin
            s_d.spm_run = 1'b0;
        end
        // Gate level status
        s_d.gate[TSG_VAL_BIT] = gate_ok;
        s_d.val_prev = s_q.gate[TSG_VAL_BIT];
        // Counter with wrap
        if (ps_tick && cnt_en)
        begin
            s_d.count = s_q.count + 16'h0001;
        end
        // Register writes; hardware sets win over clears
        if (wr_hit(bus, TSG_ADDR_CTRL))
        begin
            s_d.ctrl = bus.wdata & TSG_CTRL_WMASK;
            s_d.prescale = 3'h0;
        end
        else if (wr_hit(bus, TSG_ADDR_GATE))
        begin
            s_d.gate[7:3] = bus.wdata[7:3];
            s_d.gate[1:0] = bus.wdata[1:0];
        end
        else if (wr_hit(bus, TSG_ADDR_CNTL))
        begin
            s_d.count[7:0] = bus.wdata;
        end
        else if (wr_hit(bus, TSG_ADDR_CNTH))
        begin
            s_d.count[15:8] = bus.wdata;
        end
        else if (wr_hit(bus, TSG_ADDR_FLAG))
        begin
            s_d.rollover_flag = s_q.rollover_flag & bus.wdata[TSG_ROLL_BIT];
            s_d.gate_event_flag = s_q.gate_event_flag & bus.wdata[TSG_GEVT_BIT];
        end
        if (ps_tick && cnt_en && s_q.count == TSG_CNT_MAX)
        begin
            s_d.rollover_flag = 1'b1;
        end
        if (s_q.val_prev && !s_q.gate[TSG_VAL_BIT])
        begin
            s_d.gate_event_flag = 1'b1;
        end
        // Read data, one cycle later
        if (bus.rd)
        begin
            if (bus.addr == TSG_ADDR_CTRL)
            begin
                s_d.rdata = s_q.ctrl;
            end
            else if (bus.addr == TSG_ADDR_GATE)
            begin
                s_d.rdata = s_q.gate;
            end
            else if (bus.addr == TSG_ADDR_CNTL)
            begin
                s_d.rdata = s_q.count[7:0];
            end
            else if (bus.addr == TSG_ADDR_CNTH)
            begin
                s_d.rdata = s_q.count[15:8];
            end
            else if (bus.addr == TSG_ADDR_FLAG)
            begin
                s_d.rdata = {6'h00, s_q.gate_event_flag, s_q.rollover_flag};
            end
        end
    end

    // State register, reset clears all control
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else if (clk_en)
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign rdata = s_q.rdata;
    assign dedicated_osc_en = s_q.osc_en;
    assign rollover_flag = s_q.rollover_flag;
    assign gate_event_flag = s_q.gate_event_flag;

    // Checks
    property p_off_holds;
        @(posedge clk) disable iff (!resetn)
        clk_en && !s_q.ctrl[TSG_ON_BIT] && !bus.wr |=> $stable(s_q.count);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("count moved while off");

    property p_toggle_clear;
        @(posedge clk) disable iff (!resetn)
        clk_en && !s_q.gate[TSG_TM_BIT] |=> !s_q.toggle;
    endproperty
    a_toggle_clear: assert property (p_toggle_clear) else $error("toggle flop not held clear");

    property p_bit1_zero;
        @(posedge clk) disable iff (!resetn)
        !s_q.ctrl[1];
    endproperty
    a_bit1_zero: assert property (p_bit1_zero) else $error("control bit 1 set");

    property p_roll;
        @(posedge clk) disable iff (!resetn)
        clk_en && ps_tick && cnt_en && s_q.count == TSG_CNT_MAX && !bus.wr
        |=> s_q.count == 16'h0000 && rollover_flag;
    endproperty
    a_roll: assert property (p_roll) else $error("rollover wrong");

    property p_gevt;
        @(posedge clk) disable iff (!resetn)
        clk_en && s_q.val_prev && !s_q.gate[TSG_VAL_BIT] |=> gate_event_flag;
    endproperty
    a_gevt: assert property (p_gevt) else $error("gate event flag missed");

    property p_free_run;
        @(posedge clk) disable iff (!resetn)
        clk_en && s_q.ctrl[TSG_ON_BIT] && !s_q.gate[TSG_GE_BIT] && ps_tick && !bus.wr
        |=> s_q.count == $past(s_q.count) + 16'h0001;
    endproperty
    a_free_run: assert property (p_free_run) else $error("count missed free tick");

    property p_sys_count;
        @(posedge clk) disable iff (!resetn)
        clk_en && cs == TSG_CS_SYS && ps == 2'h0 |-> tick && ps_tick;
    endproperty
    a_sys_count: assert property (p_sys_count) else $error("system clock not counted");

    property p_osc;
        @(posedge clk) disable iff (!resetn)
        clk_en ##1 clk_en |-> dedicated_osc_en == $past(s_q.ctrl[TSG_OSC_BIT]);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");

    property p_go_clear;
        @(posedge clk) disable iff (!resetn)
        clk_en && s_q.spm_run && !gate_sel && !bus.wr |=> !s_q.gate[TSG_GO_BIT];
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("go bit not cleared");

    c_roll: cover property (@(posedge clk) disable iff (!resetn) rollover_flag);
    c_gevt: cover property (@(posedge clk) disable iff (!resetn) gate_event_flag);
    c_spm: cover property (@(posedge clk) disable iff (!resetn) s_q.spm_run ##1 !s_q.gate[TSG_GO_BIT]);
endmodule // tsg_timer

//--- bench/tsg_src_model.sv
`timescale 1ns/1ps
// Far-side sources: clock pins, gate pin, comparators, overflow pulse
module tsg_src_model
    import tsg_pkg::*;
(
    // Clock
    input wire logic clk,
    // Controls from the bench
    input wire logic run,
    input wire logic gate,
    input wire logic [1:0] cmp,
    input wire logic ovf,
    // Sources
    output tsg_pkg::tsg_src_s src
);
    logic [3:0] div_q = 4'h0;
    // Clock sources stand still unless asked to run
    always_ff @(posedge clk)
    begin
        if (run)
        begin
            div_q <= div_q + 4'h1;
        end
    end
    // Pin clock period 4, crystal period 8, sensing oscillator period 16
    assign src.ext_clk_pin = div_q[1];
    assign src.osc_clk = div_q[2];
    assign src.cap_sense_osc = div_q[3];
    // Gate sources are plain levels
    assign src.gate_pin = gate;
    assign src.cmp_one_out = cmp[0];
    assign src.cmp_two_out = cmp[1];
    assign src.ovf_pulse = ovf; // Pulse level passed straight through from the bench
endmodule // tsg_src_model

//--- bench/tb_tsg_timer.sv
`timescale 1ns/1ps
// Register-level bench for the timer gate control
module tb_tsg_timer import tsg_pkg::*;;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    tsg_bus_s bus = '0;
    logic [7:0] rdata;
    tsg_src_s src;
    logic run = 1'b0;
    logic gate = 1'b0;
    logic [1:0] cmp = 2'h0;
    logic ovf = 1'b0;
    logic ce = 1'b1;
    logic osc_en;
    logic roll;
    logic gevt;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [2:0] lv;
    // Clock at 125 MHz
    initial
    begin
        forever #4 clk = ~clk;
    end
    tsg_timer i_tsg_timer (.clk(clk), .resetn(resetn), .clk_en(ce), .bus(bus), .rdata(rdata), .src(src),
        .dedicated_osc_en(osc_en), .rollover_flag(roll), .gate_event_flag(gevt));
    tsg_src_model i_tsg_src_model (.clk(clk), .run(run), .gate(gate), .cmp(cmp), .ovf(ovf), .src(src));
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // Low count byte advance over exactly 64 cycles
    task automatic rate(input logic [7:0] exp);
        logic [7:0] c0;
        logic [7:0] c1;
        repeat (8) @(posedge clk);
        rd(TSG_ADDR_CNTL, c0);
        repeat (62) @(posedge clk);
        rd(TSG_ADDR_CNTL, c1);
        chk(c1 - c0, exp);
    endtask
    task automatic results();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            results();
        end
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        // Gate level follows the idle gate pin, active at polarity 0
        for (int a = 0; a < 6; a++) rchk(a[3:0], (a == 1) ? 8'h04 : 8'h00);
        wr(TSG_ADDR_CTRL, 8'hFF);
        rchk(TSG_ADDR_CTRL, 8'hFD);
        chk({7'h00, osc_en}, 8'h01);
        wr(TSG_ADDR_CTRL, 8'h00);
        rchk(TSG_ADDR_CTRL, 8'h00);
        run <= 1'b1;
        // Every clock source and prescale code, sync on and off
        for (int i = 0; i < 16; i++)
        begin
            wr(TSG_ADDR_CTRL, {i[3:0], 1'b0, i[0], 2'b01});
            b0 = (i[3:2] == 2'h1) ? 8'd64 : (i[3:2] == 2'h3) ? 8'd4 : 8'd16;
            rate(b0 >> i[1:0]);
        end
        wr(TSG_ADDR_CTRL, 8'hA9);
        rate(8'd2);
        // Gate sources with active-high polarity, then active-low gate pin and gate disabled
        wr(TSG_ADDR_CTRL, 8'h41);
        for (int g = 0; g < 4; g++)
        begin
            if (g == 1) continue;
            {cmp, gate} <= 3'b000;
            wr(TSG_ADDR_GATE, 8'hC0 | g[7:0]);
            rate(8'd0);
            lv = 3'b001 << ((g == 0) ? 0 : g - 1);
            {cmp, gate} <= lv;
            rate(8'd64);
            rchk(TSG_ADDR_GATE, 8'hC4 | g[7:0]);
        end
        {cmp, gate} <= 3'b000;
        wr(TSG_ADDR_GATE, 8'h80);
        rate(8'd64);
        gate <= 1'b1;
        rate(8'd0);
        wr(TSG_ADDR_GATE, 8'h40);
        rate(8'd64);
        // Clock enable low for 20 edges freezes the count
        rd(TSG_ADDR_CNTL, b0);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        rd(TSG_ADDR_CNTL, b1);
        chk(b1 - b0, 8'd2);
        wr(TSG_ADDR_CTRL, 8'h40);
        wr(TSG_ADDR_GATE, 8'h80);
        rate(8'd0);
        // Gate level fall with gate disabled
        wr(TSG_ADDR_CTRL, 8'h41);
        wr(TSG_ADDR_GATE, 8'h40);
        wr(TSG_ADDR_FLAG, 8'h00);
        rchk(TSG_ADDR_FLAG, 8'h00);
        gate <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, gevt}, 8'h01);
        // Toggle flop fed by overflow pulses
        wr(TSG_ADDR_GATE, 8'hE1);
        rate(8'd0);
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        rate(8'd64);
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        rate(8'd0);
        // Single-pulse acquisition
        wr(TSG_ADDR_GATE, 8'hD8);
        rchk(TSG_ADDR_GATE, 8'hD8);
        gate <= 1'b1;
        rate(8'd64);
        gate <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(TSG_ADDR_GATE, 8'hD0);
        gate <= 1'b1;
        rate(8'd0);
        // Rollover from all ones
        wr(TSG_ADDR_CTRL, 8'h40);
        wr(TSG_ADDR_GATE, 8'h00);
        wr(TSG_ADDR_CNTL, 8'hFF);
        wr(TSG_ADDR_CNTH, 8'hFF);
        wr(TSG_ADDR_FLAG, 8'h00);
        #1;
        chk({7'h00, roll}, 8'h00);
        wr(TSG_ADDR_CTRL, 8'h41);
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, roll}, 8'h01);
        rchk(TSG_ADDR_CNTH, 8'h00);
        // Reset in mid-run
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rchk(TSG_ADDR_CTRL, 8'h00);
        rchk(TSG_ADDR_FLAG, 8'h00);
        results();
    end
endmodule // tb_tsg_timer
